// ===== core/aex_pkg.sv
`default_nettype none
package aex_pkg;
	localparam int AEX_DW = 8;
	localparam int AEX_WW = 16;
	localparam int AEX_KW = 6;
	localparam int AEX_OFFW = 12;

	// Status register bit positions
	localparam int AEX_F_C = 0;
	localparam int AEX_F_Z = 1;
	localparam int AEX_F_N = 2;
	localparam int AEX_F_V = 3;
	localparam int AEX_F_S = 4;
	localparam int AEX_F_H = 5;
	localparam int AEX_NIB_MSB = 3;
	localparam int AEX_BYTE_MSB = 7;
	localparam int AEX_WORD_MSB = 15;

	// Which status bits each instruction class may touch
	localparam logic [7:0] AEX_MASK_ARITH = 8'h2f;
	localparam logic [7:0] AEX_MASK_WORD = 8'h1f;
	localparam logic [7:0] AEX_MASK_LOGIC = 8'h0e;
	localparam logic [7:0] AEX_MASK_NONE = 8'h00;
	localparam logic [7:0] AEX_SREG_RST = 8'h00;
	localparam logic [7:0] AEX_ALL_ONES = 8'hff;
	localparam logic [7:0] AEX_BYTE_ZERO = 8'h00;
	localparam logic [15:0] AEX_WORD_ZERO = 16'h0000;

	localparam logic [1:0] AEX_CYC_ONE = 2'h1;
	localparam logic [1:0] AEX_CYC_TWO = 2'h2;
	localparam logic [1:0] AEX_CYC_THREE = 2'h3;

	localparam logic [15:0] AEX_PC_STEP = 16'h0001;
	localparam logic [15:0] AEX_SKIP_SHORT = 16'h0002;
	localparam logic [15:0] AEX_SKIP_LONG = 16'h0003;

	typedef enum logic [4:0] {
		AEX_OP_SUM = 5'h00,
		AEX_OP_CARRY_SUM = 5'h01,
		AEX_OP_WORD_IMMEDIATE_SUM = 5'h02,
		AEX_OP_DIFF = 5'h03,
		AEX_OP_IMMEDIATE_DIFFERENCE = 5'h04,
		AEX_OP_BORROW_REGISTER_DIFFERENCE = 5'h05,
		AEX_OP_BORROW_IMMEDIATE_DIFFERENCE = 5'h06,
		AEX_OP_WORD_IMMEDIATE_DIFFERENCE = 5'h07,
		AEX_OP_CONJ = 5'h08,
		AEX_OP_BITWISE_CONJ_IMM = 5'h09,
		AEX_OP_DISJ = 5'h0a,
		AEX_OP_BITWISE_DISJ_IMM = 5'h0b,
		AEX_OP_EXCLUSIVE_DISJ_REGS = 5'h0c,
		AEX_OP_MASK_SET_BITS = 5'h0d,
		AEX_OP_MASK_CLEAR_BITS = 5'h0e,
		AEX_OP_ZERO_SIGN_CHECK = 5'h0f,
		AEX_OP_RELATIVE_JUMP = 5'h10,
		AEX_OP_POINTER_JUMP = 5'h11,
		AEX_OP_RELATIVE_CALL = 5'h12,
		AEX_OP_POINTER_CALL = 5'h13,
		AEX_OP_EQUAL_SKIP_COMPARE = 5'h14
	} aex_op_t;

	typedef enum logic [0:0] {
		AEX_ST_IDLE = 1'b0,
		AEX_ST_WAIT = 1'b1
	} aex_state_t;

	typedef struct packed {
		aex_op_t op;
		logic [7:0] rd;
		logic [7:0] rr;
		logic [7:0] imm;
		logic [15:0] pair;
		logic [15:0] ptr;
		logic [15:0] pc;
		logic [11:0] offset;
		logic next_two_words;
	} aex_req_t;

	typedef struct packed {
		logic [7:0] result;
		logic wr_byte;
		logic [15:0] pair_result;
		logic wr_pair;
		logic [15:0] pc_next;
		logic pc_load;
		logic [15:0] ret_addr;
		logic push_ret;
		logic done;
	} aex_rsp_t;
endpackage
`default_nettype wire

// ===== core/aex_byte_alu.sv
`default_nettype none
module aex_byte_alu import aex_pkg::*; (
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	input wire logic sub_i,
	output logic [7:0] res_o,
	output logic carry_o,
	output logic half_o,
	output logic ovf_o
);
	logic [8:0] full;
	logic a3, b3, r3, a7, b7, r7;

	always_comb begin
		if (sub_i) begin
			full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
		end else begin
			full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
		end
	end

	assign res_o = full[7:0];
	assign a3 = a_i[AEX_NIB_MSB];
	assign b3 = b_i[AEX_NIB_MSB];
	assign r3 = full[AEX_NIB_MSB];
	assign a7 = a_i[AEX_BYTE_MSB];
	assign b7 = b_i[AEX_BYTE_MSB];
	assign r7 = full[AEX_BYTE_MSB];

	always_comb begin
		if (sub_i) begin
			// Borrow out of bit 3 and bit 7
			half_o = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
			carry_o = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);
			ovf_o = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
		end else begin
			half_o = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
			carry_o = (a7 & b7) | (b7 & ~r7) | (~r7 & a7);
			ovf_o = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
		end
	end
endmodule
`default_nettype wire

// ===== core/aex_exec_unit.sv
// Contract
// - Register sum, optional carry, one cycle
// - Word plus small immediate, two cycles
// - Word minus small immediate, two cycles
// - Register difference, optional borrow, one cycle
// - Register minus immediate, one cycle
// - Register minus immediate and carry, one cycle
// - Conjunction updates zero, negative, overflow only
// - Inclusive/exclusive disjunction, zero/negative/overflow flags
// - Immediate mask sets bits, one cycle
// - Immediate mask clears bits via inverted mask
// - Self-conjunction test leaves register unchanged
// - Pointer jump/call loads pc from pointer
`default_nettype none
module aex_exec_unit import aex_pkg::*; (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire aex_req_t req_i,
	output logic busy_o,
	output aex_rsp_t rsp_o,
	output logic [7:0] sreg_o
);
	aex_state_t state_reg;
	logic [1:0] cnt_reg;
	aex_rsp_t hold_reg;
	logic [7:0] hold_sreg_reg;
	logic [7:0] sreg_reg;

	logic accept;
	logic [7:0] op_b;
	logic alu_cin;
	logic alu_sub;
	logic [7:0] alu_res;
	logic alu_c, alu_h, alu_v;

	logic [7:0] flags_new;
	logic [7:0] flag_mask;
	logic [7:0] sreg_next;
	logic [1:0] cyc_next;
	aex_rsp_t rsp_next;

	logic [7:0] logic_res;
	logic [15:0] word_k;
	logic [15:0] word_res;
	logic word_v, word_c;
	logic [15:0] rel_target;
	logic [15:0] seq_pc;
	logic regs_equal;

	assign accept = start_i & (state_reg == AEX_ST_IDLE);

	aex_byte_alu u_byte_alu (
		.a_i(req_i.rd),
		.b_i(op_b),
		.cin_i(alu_cin),
		.sub_i(alu_sub),
		.res_o(alu_res),
		.carry_o(alu_c),
		.half_o(alu_h),
		.ovf_o(alu_v)
	);

	// Operand selection for the byte datapath
	always_comb begin
		op_b = req_i.rr;
		alu_cin = 1'b0;
		alu_sub = 1'b0;
		case (req_i.op)
			AEX_OP_CARRY_SUM: begin
				alu_cin = sreg_reg[AEX_F_C];
			end
			AEX_OP_DIFF: begin
				alu_sub = 1'b1;
			end
			AEX_OP_BORROW_REGISTER_DIFFERENCE: begin
				alu_sub = 1'b1;
				alu_cin = sreg_reg[AEX_F_C];
			end
			AEX_OP_IMMEDIATE_DIFFERENCE: begin
				alu_sub = 1'b1;
				op_b = req_i.imm;
			end
			AEX_OP_BORROW_IMMEDIATE_DIFFERENCE: begin
				alu_sub = 1'b1;
				op_b = req_i.imm;
				alu_cin = sreg_reg[AEX_F_C];
			end
			default: begin
				op_b = req_i.rr;
			end
		endcase
	end

	// Bitwise results
	always_comb begin
		case (req_i.op)
			AEX_OP_CONJ: logic_res = req_i.rd & req_i.rr;
			AEX_OP_BITWISE_CONJ_IMM: logic_res = req_i.rd & req_i.imm;
			AEX_OP_DISJ: logic_res = req_i.rd | req_i.rr;
			AEX_OP_BITWISE_DISJ_IMM: logic_res = req_i.rd | req_i.imm;
			AEX_OP_EXCLUSIVE_DISJ_REGS: logic_res = req_i.rd ^ req_i.rr;
			AEX_OP_MASK_SET_BITS: logic_res = req_i.rd | req_i.imm;
			AEX_OP_MASK_CLEAR_BITS: begin
				logic_res = req_i.rd & (AEX_ALL_ONES - req_i.imm);
			end
			AEX_OP_ZERO_SIGN_CHECK: logic_res = req_i.rd & req_i.rd;
			default: logic_res = AEX_BYTE_ZERO;
		endcase
	end

	// Word datapath; the constant is only six bits wide
	assign word_k = {{(AEX_WW - AEX_KW){1'b0}}, req_i.imm[AEX_KW-1:0]};

	always_comb begin
		if (req_i.op == AEX_OP_WORD_IMMEDIATE_DIFFERENCE) begin
			word_res = req_i.pair - word_k;
			word_v = req_i.pair[AEX_WORD_MSB] & ~word_res[AEX_WORD_MSB];
			word_c = word_res[AEX_WORD_MSB] & ~req_i.pair[AEX_WORD_MSB];
		end else begin
			word_res = req_i.pair + word_k;
			word_v = ~req_i.pair[AEX_WORD_MSB] & word_res[AEX_WORD_MSB];
			word_c = ~word_res[AEX_WORD_MSB] & req_i.pair[AEX_WORD_MSB];
		end
	end

	// Program flow targets
	assign rel_target = req_i.pc
		+ {{(AEX_WW - AEX_OFFW){req_i.offset[AEX_OFFW-1]}}, req_i.offset}
		+ AEX_PC_STEP;
	assign seq_pc = req_i.pc + AEX_PC_STEP;
	assign regs_equal = (req_i.rd == req_i.rr);

	// Decode of result, flags and cycle count
	always_comb begin
		rsp_next = '0;
		rsp_next.done = 1'b1;
		rsp_next.ret_addr = seq_pc;
		flags_new = sreg_reg;
		flag_mask = AEX_MASK_NONE;
		cyc_next = AEX_CYC_ONE;
		case (req_i.op)
			AEX_OP_SUM, AEX_OP_CARRY_SUM, AEX_OP_DIFF,
			AEX_OP_IMMEDIATE_DIFFERENCE,
			AEX_OP_BORROW_REGISTER_DIFFERENCE,
			AEX_OP_BORROW_IMMEDIATE_DIFFERENCE: begin
				rsp_next.result = alu_res;
				rsp_next.wr_byte = 1'b1;
				flag_mask = AEX_MASK_ARITH;
				flags_new[AEX_F_C] = alu_c;
				flags_new[AEX_F_H] = alu_h;
				flags_new[AEX_F_V] = alu_v;
				flags_new[AEX_F_N] = alu_res[AEX_BYTE_MSB];
				flags_new[AEX_F_Z] = (alu_res == AEX_BYTE_ZERO);
				// With carry set, carry and borrow chains keep zero only if the lower byte was zero
				if (alu_cin) begin
					flags_new[AEX_F_Z] = (alu_res == AEX_BYTE_ZERO)
						& sreg_reg[AEX_F_Z];
				end
			end
			AEX_OP_WORD_IMMEDIATE_SUM,
			AEX_OP_WORD_IMMEDIATE_DIFFERENCE: begin
				rsp_next.pair_result = word_res;
				rsp_next.wr_pair = 1'b1;
				flag_mask = AEX_MASK_WORD;
				flags_new[AEX_F_C] = word_c;
				flags_new[AEX_F_V] = word_v;
				flags_new[AEX_F_N] = word_res[AEX_WORD_MSB];
				flags_new[AEX_F_S] = word_res[AEX_WORD_MSB] ^ word_v;
				flags_new[AEX_F_Z] = (word_res == AEX_WORD_ZERO);
				cyc_next = AEX_CYC_TWO;
			end
			AEX_OP_CONJ, AEX_OP_BITWISE_CONJ_IMM, AEX_OP_DISJ,
			AEX_OP_BITWISE_DISJ_IMM, AEX_OP_EXCLUSIVE_DISJ_REGS,
			AEX_OP_MASK_SET_BITS, AEX_OP_MASK_CLEAR_BITS,
			AEX_OP_ZERO_SIGN_CHECK: begin
				rsp_next.result = logic_res;
				// Test only reads; writing back the same value is pointless
				rsp_next.wr_byte = (req_i.op != AEX_OP_ZERO_SIGN_CHECK);
				flag_mask = AEX_MASK_LOGIC;
				flags_new[AEX_F_V] = 1'b0;
				flags_new[AEX_F_N] = logic_res[AEX_BYTE_MSB];
				flags_new[AEX_F_Z] = (logic_res == AEX_BYTE_ZERO);
			end
			AEX_OP_RELATIVE_JUMP: begin
				rsp_next.pc_next = rel_target;
				rsp_next.pc_load = 1'b1;
				cyc_next = AEX_CYC_TWO;
			end
			AEX_OP_RELATIVE_CALL: begin
				rsp_next.pc_next = rel_target;
				rsp_next.pc_load = 1'b1;
				rsp_next.push_ret = 1'b1;
				cyc_next = AEX_CYC_THREE;
			end
			AEX_OP_POINTER_JUMP: begin
				rsp_next.pc_next = req_i.ptr;
				rsp_next.pc_load = 1'b1;
				cyc_next = AEX_CYC_TWO;
			end
			AEX_OP_POINTER_CALL: begin
				rsp_next.pc_next = req_i.ptr;
				rsp_next.pc_load = 1'b1;
				rsp_next.push_ret = 1'b1;
				cyc_next = AEX_CYC_THREE;
			end
			AEX_OP_EQUAL_SKIP_COMPARE: begin
				rsp_next.pc_load = 1'b1;
				rsp_next.pc_next = seq_pc;
				if (regs_equal && req_i.next_two_words) begin
					rsp_next.pc_next = req_i.pc + AEX_SKIP_LONG;
					cyc_next = AEX_CYC_THREE;
				end else if (regs_equal) begin
					rsp_next.pc_next = req_i.pc + AEX_SKIP_SHORT;
					cyc_next = AEX_CYC_TWO;
				end
			end
			default: begin
				rsp_next.done = 1'b1;
			end
		endcase
	end

	// Masked merge so untouched flags stay as they were
	assign sreg_next = (sreg_reg & ~flag_mask)
		| (flags_new & flag_mask);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= AEX_ST_IDLE;
			cnt_reg <= 2'h0;
		end else begin
			case (state_reg)
				AEX_ST_IDLE: if (accept && cyc_next != AEX_CYC_ONE) begin
					state_reg <= AEX_ST_WAIT;
					cnt_reg <= cyc_next - AEX_CYC_ONE;
				end
				AEX_ST_WAIT: begin
					cnt_reg <= cnt_reg - AEX_CYC_ONE;
					if (cnt_reg == AEX_CYC_ONE) begin
						state_reg <= AEX_ST_IDLE;
					end
				end
				default: state_reg <= AEX_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_o <= 1'b0;
		end else if (accept && cyc_next != AEX_CYC_ONE) begin
			busy_o <= 1'b1;
		end else if (state_reg == AEX_ST_WAIT && cnt_reg == AEX_CYC_ONE) begin
			busy_o <= 1'b0;
		end
	end

	// Multi-cycle results wait here until their last cycle
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hold_reg <= '0;
			hold_sreg_reg <= AEX_SREG_RST;
		end else if (accept) begin
			hold_reg <= rsp_next;
			hold_sreg_reg <= sreg_next;
		end
	end

	// Answer fields are pulses for one cycle each
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_o <= '0;
		end else if (accept && cyc_next == AEX_CYC_ONE) begin
			rsp_o <= rsp_next;
		end else if (state_reg == AEX_ST_WAIT && cnt_reg == AEX_CYC_ONE) begin
			rsp_o <= hold_reg;
		end else begin
			rsp_o <= '0;
		end
	end

	// Flags become visible together with done
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sreg_reg <= AEX_SREG_RST;
		end else if (accept && cyc_next == AEX_CYC_ONE) begin
			sreg_reg <= sreg_next;
		end else if (state_reg == AEX_ST_WAIT && cnt_reg == AEX_CYC_ONE) begin
			sreg_reg <= hold_sreg_reg;
		end
	end

	assign sreg_o = sreg_reg;
endmodule
`default_nettype wire

// ===== tb/aex_chk.sv
`default_nettype none
module aex_chk import aex_pkg::*; (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire aex_req_t req_i,
	input wire logic busy_o,
	input wire aex_rsp_t rsp_o,
	input wire logic [7:0] sreg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	logic acc;
	// A request held while busy is dropped, so only idle edges count
	assign acc = start_i && !busy_o;
	a_sum_value:
	assert property (acc && req_i.op == AEX_OP_SUM |=> rsp_o.done &&
		rsp_o.result == $past(req_i.rd) + $past(req_i.rr))
	else $error("sum result or timing wrong");
	a_word_two:
	assert property (acc && req_i.op == AEX_OP_WORD_IMMEDIATE_SUM |=>
		busy_o && !rsp_o.done ##1 rsp_o.done && rsp_o.wr_pair && !busy_o)
	else $error("word sum not done in two cycles");
	a_diff_value:
	assert property (acc && req_i.op == AEX_OP_DIFF |=> rsp_o.done &&
		rsp_o.result == $past(req_i.rd) - $past(req_i.rr))
	else $error("difference wrong");
	a_logic_flags:
	assert property (acc && req_i.op inside
		{[AEX_OP_CONJ:AEX_OP_ZERO_SIGN_CHECK]} |=> !sreg_o[AEX_F_V] &&
		(sreg_o & 8'h31) == ($past(sreg_o) & 8'h31))
	else $error("logic op touched foreign flags");
	a_relative_call_three:
	assert property (acc && req_i.op == AEX_OP_RELATIVE_CALL |=>
		busy_o [*2] ##1 rsp_o.done && rsp_o.push_ret && !busy_o)
	else $error("relative call not three cycles");
	a_ptr_jump:
	assert property (acc && req_i.op == AEX_OP_POINTER_JUMP |=> !rsp_o.done
		##1 rsp_o.done && rsp_o.pc_next == $past(req_i.ptr, 2))
	else $error("pointer jump target wrong");
	a_skip_miss:
	assert property (acc && req_i.op == AEX_OP_EQUAL_SKIP_COMPARE &&
		req_i.rd != req_i.rr |=> rsp_o.done &&
		rsp_o.pc_next == $past(req_i.pc) + 16'h0001)
	else $error("unequal compare did not step by one");
	a_flow_flags:
	assert property (rsp_o.done && rsp_o.pc_load |-> $stable(sreg_o))
	else $error("flow op changed flags");
	cover property (rsp_o.wr_pair);
	cover property (rsp_o.push_ret);
	cover property (rsp_o.done && !rsp_o.wr_byte && !rsp_o.pc_load);
endmodule
bind aex_exec_unit aex_chk i_aex_chk(.clock_i, .resetn_i, .start_i, .req_i,
	.busy_o, .rsp_o, .sreg_o);
`default_nettype wire

// ===== tb/aex_core_model.sv
`default_nettype none
module aex_core_model import aex_pkg::*; (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire aex_rsp_t rsp_i,
	output logic [15:0] pc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Fetch side only moves on a finished flow op, never on a bare pulse
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			pc_o <= 16'h0000;
		else if (rsp_i.done && rsp_i.pc_load)
			pc_o <= rsp_i.pc_next;
	end
endmodule
`default_nettype wire

// ===== tb/eight_bit_alu_branch_exec_bench.sv
`default_nettype none
module eight_bit_alu_branch_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import aex_pkg::*;
	logic clock_i, resetn_i, start_i, busy_o;
	aex_req_t req_i;
	aex_rsp_t rsp_o;
	logic [7:0] sreg_o, fl;
	logic [15:0] pc_seen;
	int n_errors = 0, n_tests = 0, cyc = 0;
	aex_exec_unit i_aex_exec_unit(.clock_i, .resetn_i, .start_i, .req_i,
		.busy_o, .rsp_o, .sreg_o);
	aex_core_model i_aex_core_model(.clock_i, .resetn_i, .rsp_i(rsp_o),
		.pc_o(pc_seen));
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk_v(string s, logic [15:0] got, logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", s, exp, got);
		end
	endtask
	task automatic chk_f(logic [7:0] exp);
		n_tests++;
		fl = exp;
		if (sreg_o !== exp) begin
			n_errors++;
			$display("unexpected flags exp %h got %h", exp, sreg_o);
		end
	endtask
	// Start stays up after a one-cycle op so back-to-back calls never
	// assign it twice in one step; the next call replaces the request
	task automatic issue(aex_req_t q, int c);
		int n;
		n = 0;
		start_i = 1'b1;
		req_i = q;
		do begin
			@(posedge clock_i);
			#1;
			if (rsp_o.done !== 1'b1)
				start_i = 1'b0;
			n++;
		end while (rsp_o.done !== 1'b1 && n < 8);
		chk_v("cycles", 16'(n), 16'(c));
	endtask
	task automatic op8(aex_op_t o, logic [7:0] d, b, res, f);
		issue('{op: o, rd: d, rr: b, imm: b, default: '0}, 1);
		chk_v("result", {rsp_o.wr_byte, rsp_o.result},
			{o != AEX_OP_ZERO_SIGN_CHECK, res});
		chk_f(f);
	endtask
	task automatic wd(aex_op_t o, logic [15:0] p, logic [7:0] k,
		logic [15:0] e, logic [7:0] f);
		issue('{op: o, pair: p, imm: k, default: '0}, 2);
		chk_v("pair", rsp_o.pair_result, e);
		chk_f(f);
	endtask
	task automatic go(aex_op_t o, logic [15:0] pc, logic [11:0] off,
		logic [7:0] r, int c, logic [15:0] e);
		issue('{op: o, pc: pc, ptr: pc, offset: off, rd: 8'h05, rr: r,
			next_two_words: c == 3, default: '0}, c);
		chk_v("pc", rsp_o.pc_next, e);
		if (o == AEX_OP_RELATIVE_CALL || o == AEX_OP_POINTER_CALL)
			chk_v("ret", rsp_o.ret_addr, pc + 16'h0001);
		chk_f(fl);
	endtask
	initial begin
		start_i = 1'b0;
		req_i = '0;
		resetn_i = 1'b0;
		fl = 8'h00;
		repeat (4) @(posedge clock_i);
		#1 resetn_i = 1'b1;
		chk_f(8'h00);
		op8(AEX_OP_SUM, 8'h8f, 8'h81, 8'h10, 8'h29);
		op8(AEX_OP_CARRY_SUM, 8'h01, 8'h01, 8'h03, 8'h00);
		wd(AEX_OP_WORD_IMMEDIATE_SUM, 16'hffff, 8'h01, 16'h0, 8'h03);
		wd(AEX_OP_WORD_IMMEDIATE_DIFFERENCE, 16'h0, 8'h01, 16'hffff, 8'h15);
		op8(AEX_OP_BORROW_REGISTER_DIFFERENCE, 8'h10, 8'h01, 8'h0e, 8'h30);
		op8(AEX_OP_DIFF, 8'h10, 8'h01, 8'h0f, 8'h30);
		op8(AEX_OP_IMMEDIATE_DIFFERENCE, 8'h80, 8'h01, 8'h7f, 8'h38);
		// Carry clear here, so zero is not chained to the old flag
		op8(AEX_OP_BORROW_IMMEDIATE_DIFFERENCE, 8'h05, 8'h05, 8'h00, 8'h12);
		$display("arithmetic tests done");
		op8(AEX_OP_CONJ, 8'hf0, 8'h0f, 8'h00, 8'h12);
		op8(AEX_OP_BITWISE_CONJ_IMM, 8'hff, 8'h80, 8'h80, 8'h14);
		op8(AEX_OP_DISJ, 8'h00, 8'h00, 8'h00, 8'h12);
		op8(AEX_OP_BITWISE_DISJ_IMM, 8'h80, 8'h01, 8'h81, 8'h14);
		op8(AEX_OP_EXCLUSIVE_DISJ_REGS, 8'hff, 8'hff, 8'h00, 8'h12);
		op8(AEX_OP_MASK_SET_BITS, 8'h01, 8'h80, 8'h81, 8'h14);
		op8(AEX_OP_MASK_CLEAR_BITS, 8'hff, 8'h0f, 8'hf0, 8'h14);
		op8(AEX_OP_ZERO_SIGN_CHECK, 8'h00, 8'h00, 8'h00, 8'h12);
		$display("logic tests done");
		go(AEX_OP_RELATIVE_JUMP, 16'h100, 12'hfff, 8'h0, 2, 16'h100);
		go(AEX_OP_RELATIVE_CALL, 16'h100, 12'h010, 8'h0, 3, 16'h111);
		go(AEX_OP_POINTER_JUMP, 16'h1234, 12'h0, 8'h0, 2, 16'h1234);
		go(AEX_OP_POINTER_CALL, 16'h4321, 12'h0, 8'h0, 3, 16'h4321);
		go(AEX_OP_EQUAL_SKIP_COMPARE, 16'h300, 12'h0, 8'h4, 1, 16'h301);
		go(AEX_OP_EQUAL_SKIP_COMPARE, 16'h300, 12'h0, 8'h5, 2, 16'h302);
		go(AEX_OP_EQUAL_SKIP_COMPARE, 16'h300, 12'h0, 8'h5, 3, 16'h303);
		@(posedge clock_i);
		#1;
		chk_v("model pc", pc_seen, 16'h0303);
		$display("flow tests done");
		end_of_test();
	end
endmodule
`default_nettype wire
